/* pkg/bfp_pkg.sv */
package bfp_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_HZ = 20000000;
  localparam int HALF_CYCLE_MS = 10; // half cycle of 50 Hz
  localparam int HALF_CYCLE_CLKS = (CLK_HZ / 1000) * HALF_CYCLE_MS;
  localparam int TMR_W = 24;
  localparam logic [TMR_W-1:0] TMR_ZERO = 24'h000000;
  localparam logic [TMR_W-1:0] TMR_ONE = 24'h000001;

  // ************************************************************
  // initiation sources and reset options
  // ************************************************************
  typedef enum logic [1:0] {
    BFP_INIT_CURRENT,
    BFP_INIT_SEF,
    BFP_INIT_NONCURRENT,
    BFP_INIT_EXTERNAL
  } bfp_init_e;

  typedef enum logic [1:0] {
    BFP_RST_UC_ONLY,
    BFP_RST_PROT_RESET,
    BFP_RST_CB_OPEN
  } bfp_rst_opt_e;

  // undercurrent detector states, one bit each
  typedef struct packed {
    logic phase_a_undercurrent;
    logic phase_b_undercurrent;
    logic phase_c_undercurrent;
    logic neutral_undercurrent;
    logic sensitive_earth_undercurrent;
  } bfp_uc_s;

  // trip initiations, one bit per source
  typedef struct packed {
    logic current_trip;
    logic sef_trip;
    logic noncurrent_trip;
    logic external_trip;
  } bfp_trip_s;

endpackage : bfp_pkg

/* hdl/bfp_timer.sv */
`timescale 1ns/100ps

module bfp_timer #(
  parameter int W = 24
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic start,
  input wire logic clear,
  input wire logic [W-1:0] delay,
  output logic expired
);

  logic running_ff;
  logic nxt_running;
  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;
  logic expired_ff;
  logic nxt_expired;

  // ************************************************************
  // count ticks; expiry latches until clear or enable low
  // ************************************************************
  always_comb
  begin
    nxt_running = running_ff;
    nxt_count = count_ff;
    nxt_expired = expired_ff;
    if (clear || !enable)
    begin
      nxt_running = 1'b0;
      nxt_count = '0;
      nxt_expired = 1'b0;
    end
    else if (start && !running_ff && !expired_ff)
    begin
      nxt_running = 1'b1;
      nxt_count = '0;
    end
    else if (running_ff)
    begin
      if (count_ff >= delay)
      begin
        nxt_running = 1'b0;
        nxt_expired = 1'b1;
      end
      else
      begin
        nxt_count = count_ff + W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      running_ff <= 1'b0;
      count_ff <= '0;
      expired_ff <= 1'b0;
    end
    else
    begin
      running_ff <= nxt_running;
      count_ff <= nxt_count;
      expired_ff <= nxt_expired;
    end
  end

  assign expired = expired_ff;

  a_expiry_holds: assert property (@(posedge clk) disable iff (!rst_b)
    expired_ff && !clear && enable |=> expired_ff)
    else $error("timer expiry dropped without clear");

endmodule : bfp_timer

/* hdl/bfp_top.sv */
`timescale 1ns/100ps
// Function
// - timer one starts on initiating trip, timer two too in retrip mode
// - simple mode: timer one gives backtrip
// - retrip mode: timer one gives retrip
// - retrip mode: timer two gives backtrip
// - initiation selectable internal or external
// - every reset needs undercurrents reset-qualified
// - current initiation resets on phase and neutral undercurrents
// - sef initiation resets on sef undercurrent
// - non-current reset: three selectable options
// - external reset: three selectable options
// - separate reset setting for non-current and external initiation
// - same-sign half cycle blocks trip outputs
// - zero-crossing applies after breaker open
// - breaker fail may reset start outputs

module bfp_top #(
  parameter int TMR_W = bfp_pkg::TMR_W,
  parameter int HALF_CYCLE = bfp_pkg::HALF_CYCLE_CLKS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic use_external, // initiation source select
  input wire logic retrip_mode, // 0 simple, 1 retrip plus backtrip
  input wire logic reset_starts_en, // clear start outputs on failure
  input wire bfp_pkg::bfp_rst_opt_e noncurrent_rst_opt,
  input wire bfp_pkg::bfp_rst_opt_e external_rst_opt,
  input wire logic [TMR_W-1:0] first_delay,
  input wire logic [TMR_W-1:0] second_delay,
  input wire bfp_pkg::bfp_trip_s trips,
  input wire bfp_pkg::bfp_uc_s uc,
  input wire logic cb_all_poles_open,
  input wire logic sample_valid,
  input wire logic sample_negative,
  input wire logic [3:0] starts_in,
  output logic retrip,
  output logic backtrip,
  output logic zcd_active,
  output logic [3:0] starts_out
);

  // ************************************************************
  // initiation latch
  // ************************************************************
  bfp_pkg::bfp_init_e src_ff;
  bfp_pkg::bfp_init_e nxt_src;
  logic active_ff;
  logic nxt_active;
  logic init_any;
  logic uc_all;
  logic clear_tmr;
  logic t1_exp;
  logic t2_exp;
  logic prot_reset;
  bfp_pkg::bfp_rst_opt_e opt_sel;

  // internal elements used unless external selected
  always_comb
  begin
    if (use_external)
      init_any = trips.external_trip;
    else
      init_any = trips.current_trip | trips.sef_trip | trips.noncurrent_trip;
  end

  // source priority: current, sef, non-current
  always_comb
  begin
    nxt_src = src_ff;
    nxt_active = active_ff;
    if (clear_tmr)
      nxt_active = 1'b0;
    else if (init_any && !active_ff)
    begin
      nxt_active = 1'b1;
      if (use_external)
        nxt_src = bfp_pkg::BFP_INIT_EXTERNAL;
      else if (trips.current_trip)
        nxt_src = bfp_pkg::BFP_INIT_CURRENT;
      else if (trips.sef_trip)
        nxt_src = bfp_pkg::BFP_INIT_SEF;
      else
        nxt_src = bfp_pkg::BFP_INIT_NONCURRENT;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      src_ff <= bfp_pkg::BFP_INIT_CURRENT;
      active_ff <= 1'b0;
    end
    else
    begin
      src_ff <= nxt_src;
      active_ff <= nxt_active;
    end
  end

  // ************************************************************
  // reset mechanism
  // ************************************************************
  assign uc_all = uc.phase_a_undercurrent & uc.phase_b_undercurrent & uc.phase_c_undercurrent
                & uc.neutral_undercurrent;

  // non-current and external initiations each have their own option setting
  always_comb
  begin
    opt_sel = bfp_pkg::BFP_RST_UC_ONLY;
    prot_reset = 1'b0;
    clear_tmr = 1'b0;
    case (src_ff)
      bfp_pkg::BFP_INIT_CURRENT:
        clear_tmr = active_ff & uc_all;
      bfp_pkg::BFP_INIT_SEF:
        clear_tmr = active_ff & uc.sensitive_earth_undercurrent;
      bfp_pkg::BFP_INIT_NONCURRENT:
      begin
        opt_sel = noncurrent_rst_opt;
        prot_reset = !trips.noncurrent_trip;
      end
      bfp_pkg::BFP_INIT_EXTERNAL:
      begin
        opt_sel = external_rst_opt;
        prot_reset = !trips.external_trip;
      end
      default:
        clear_tmr = 1'b0;
    endcase
    if (src_ff == bfp_pkg::BFP_INIT_NONCURRENT || src_ff == bfp_pkg::BFP_INIT_EXTERNAL)
    begin
      // undercurrent always qualifies, so a jammed pole cannot reset us
      case (opt_sel)
        bfp_pkg::BFP_RST_UC_ONLY: clear_tmr = active_ff & uc_all;
        bfp_pkg::BFP_RST_PROT_RESET: clear_tmr = active_ff & prot_reset & uc_all;
        bfp_pkg::BFP_RST_CB_OPEN: clear_tmr = active_ff & cb_all_poles_open & uc_all;
        default: clear_tmr = active_ff & uc_all;
      endcase
    end
  end

  // ************************************************************
  // failure timers
  // ************************************************************
  bfp_timer #(.W(TMR_W)) u_first_failure_timer (
    .clk(clk),
    .rst_b(rst_b),
    .enable(1'b1),
    .start(init_any),
    .clear(clear_tmr),
    .delay(first_delay),
    .expired(t1_exp)
  );

  // only enabled in retrip mode
  bfp_timer #(.W(TMR_W)) u_second_failure_timer (
    .clk(clk),
    .rst_b(rst_b),
    .enable(retrip_mode),
    .start(init_any),
    .clear(clear_tmr),
    .delay(second_delay),
    .expired(t2_exp)
  );

  // ************************************************************
  // zero crossing detector
  // ************************************************************
  logic [TMR_W-1:0] zc_cnt_ff;
  logic [TMR_W-1:0] nxt_zc_cnt;
  logic sign_ff;
  logic nxt_sign;
  logic zcd_ff;
  logic nxt_zcd;

  // only after breaker opens is subsidence the sole current
  always_comb
  begin
    nxt_zc_cnt = zc_cnt_ff;
    nxt_sign = sign_ff;
    nxt_zcd = zcd_ff;
    if (!cb_all_poles_open)
    begin
      nxt_zc_cnt = bfp_pkg::TMR_ZERO;
      nxt_zcd = 1'b0;
    end
    else if (sample_valid)
    begin
      nxt_sign = sample_negative;
      if (sample_negative != sign_ff)
      begin
        nxt_zc_cnt = bfp_pkg::TMR_ZERO;
        nxt_zcd = 1'b0;
      end
      else if (zc_cnt_ff >= TMR_W'(HALF_CYCLE))
        nxt_zcd = 1'b1;
      else
        nxt_zc_cnt = zc_cnt_ff + bfp_pkg::TMR_ONE;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      zc_cnt_ff <= bfp_pkg::TMR_ZERO;
      sign_ff <= 1'b0;
      zcd_ff <= 1'b0;
    end
    else
    begin
      zc_cnt_ff <= nxt_zc_cnt;
      sign_ff <= nxt_sign;
      zcd_ff <= nxt_zcd;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  logic retrip_ff;
  logic backtrip_ff;
  logic [3:0] starts_ff;
  logic nxt_retrip;
  logic nxt_backtrip;
  logic [3:0] nxt_starts;

  // zcd blocks both outputs while subsidence current flows
  always_comb
  begin
    nxt_retrip = retrip_mode & t1_exp & !nxt_zcd;
    if (retrip_mode)
      nxt_backtrip = t2_exp & !nxt_zcd;
    else
      nxt_backtrip = t1_exp & !nxt_zcd;
    nxt_starts = (reset_starts_en && nxt_backtrip) ? 4'h0 : starts_in;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      retrip_ff <= 1'b0;
      backtrip_ff <= 1'b0;
      starts_ff <= 4'h0;
    end
    else
    begin
      retrip_ff <= nxt_retrip;
      backtrip_ff <= nxt_backtrip;
      starts_ff <= nxt_starts;
    end
  end

  assign retrip = retrip_ff;
  assign backtrip = backtrip_ff;
  assign zcd_active = zcd_ff;
  assign starts_out = starts_ff;

  a_zcd_blocks: assert property (@(posedge clk) disable iff (!rst_b)
    zcd_ff |-> !retrip_ff && !backtrip_ff)
    else $error("trip output while zero crossing asserted");
  a_simple_no_retrip: assert property (@(posedge clk) disable iff (!rst_b)
    !$past(retrip_mode) |-> !retrip_ff)
    else $error("retrip in simple mode");
  a_retrip_cause: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(retrip_ff) |-> $past(t1_exp) && $past(retrip_mode))
    else $error("retrip without first timer expiry");
  a_backtrip_cause: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(backtrip_ff) |-> $past(retrip_mode) ? $past(t2_exp) : $past(t1_exp))
    else $error("backtrip without timer expiry");
  a_reset_qualified: assert property (@(posedge clk) disable iff (!rst_b)
    clear_tmr && src_ff != bfp_pkg::BFP_INIT_SEF |-> uc_all)
    else $error("timer reset without undercurrent");
  a_sef_reset: assert property (@(posedge clk) disable iff (!rst_b)
    active_ff && src_ff == bfp_pkg::BFP_INIT_SEF && uc.sensitive_earth_undercurrent |=> !active_ff)
    else $error("sef initiation not reset");
  a_zcd_needs_open: assert property (@(posedge clk) disable iff (!rst_b)
    !cb_all_poles_open |=> !zcd_ff)
    else $error("zero crossing asserted with breaker closed");
  a_starts_cleared: assert property (@(posedge clk) disable iff (!rst_b)
    backtrip_ff && $past(reset_starts_en) |-> starts_ff == 4'h0)
    else $error("start outputs kept during breaker fail");

endmodule : bfp_top

/* tb/bfp_far_model.sv */
`timescale 1ns/100ps
// ****
// breaker and protection side
// ****
module bfp_far_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic fault,
  input wire logic [1:0] src,
  input wire logic rel,
  input wire logic cb_resp,
  input wire logic cb_cmd,
  input wire logic subs,
  input wire bfp_pkg::bfp_uc_s uc_set,
  input wire logic retrip,
  input wire logic backtrip,
  output bfp_pkg::bfp_trip_s trips,
  output bfp_pkg::bfp_uc_s uc,
  output logic cb_open,
  output logic sample_valid,
  output logic sample_negative
);
  logic open_ff;

  // breaker opens on command or on an obeyed trip; decaying current keeps one sign
  always_ff @(negedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      open_ff <= 1'b0;
      sample_negative <= 1'b0;
    end
    else
    begin
      open_ff <= cb_cmd | (cb_resp & (retrip | backtrip)) | (open_ff & fault);
      sample_negative <= subs ? 1'b0 : !sample_negative;
    end
  end

  // one sample per clock keeps the half cycle short
  assign cb_open = open_ff;
  assign sample_valid = 1'b1;
  assign trips = bfp_pkg::bfp_trip_s'((fault && !open_ff && !rel) ? (4'h8 >> src) : 4'h0);
  // thresholds below load and earth trip, so no current reads operated
  assign uc = (open_ff ? !subs : !fault) ? bfp_pkg::bfp_uc_s'(5'h1F) : uc_set;
endmodule : bfp_far_model

/* tb/breaker_failure_protection_tb_top.sv */
`timescale 1ns/100ps
// ****
// breaker failure bench
// ****
module breaker_failure_protection_tb_top;
  localparam int HC = 8;
  // delays keep a trip relay margin
  localparam int D1 = 32'h14;
  localparam int D2 = 32'h28;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic use_external = 1'b0;
  logic retrip_mode = 1'b0;
  logic reset_starts_en = 1'b0;
  bfp_pkg::bfp_rst_opt_e nc_opt = bfp_pkg::BFP_RST_UC_ONLY;
  bfp_pkg::bfp_rst_opt_e ex_opt = bfp_pkg::BFP_RST_UC_ONLY;
  logic [3:0] starts_in = 4'hA;
  logic fault = 1'b0;
  logic rel = 1'b0;
  logic cb_resp = 1'b0;
  logic cb_cmd = 1'b0;
  logic subs = 1'b0;
  logic [1:0] src = 2'h0;
  bfp_pkg::bfp_uc_s uc_set = 5'h00;
  bfp_pkg::bfp_trip_s trips;
  bfp_pkg::bfp_uc_s uc;
  logic cb_open, sample_valid, sample_negative, retrip, backtrip, zcd_active;
  logic [3:0] starts_out;
  int bad_count = 0;
  int n_checks = 0;

  initial
  begin
    forever #25 clk = !clk;
  end

  bfp_top #(.TMR_W(24), .HALF_CYCLE(HC)) DUT (
    .clk(clk), .rst_b(rst_b), .use_external(use_external), .retrip_mode(retrip_mode),
    .reset_starts_en(reset_starts_en), .noncurrent_rst_opt(nc_opt), .external_rst_opt(ex_opt),
    .first_delay(24'(D1)), .second_delay(24'(D2)), .trips(trips), .uc(uc), .cb_all_poles_open(cb_open),
    .sample_valid(sample_valid), .sample_negative(sample_negative), .starts_in(starts_in),
    .retrip(retrip), .backtrip(backtrip), .zcd_active(zcd_active), .starts_out(starts_out));

  bfp_far_model far (
    .clk(clk), .rst_b(rst_b), .fault(fault), .src(src), .rel(rel), .cb_resp(cb_resp), .cb_cmd(cb_cmd),
    .subs(subs), .uc_set(uc_set), .retrip(retrip), .backtrip(backtrip), .trips(trips), .uc(uc),
    .cb_open(cb_open), .sample_valid(sample_valid), .sample_negative(sample_negative));

  // ****
  // checking tasks
  // ****
  task results;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : results

  task chk(input logic [3:0] seen, input logic [3:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic logic pick(input int w);
    return (w == 0) ? retrip : (w == 1) ? backtrip : zcd_active;
  endfunction : pick

  // bounded wait; running out ends the run
  task wt(input int n, input int w, input logic v);
    for (int i = 0; i < n && pick(w) !== v; i++)
      @(negedge clk);
    if (pick(w) !== v)
    begin
      chk({3'h0, pick(w)}, {3'h0, v});
      results();
    end
  endtask : wt

  task hold(input int n, input int w, input logic v);
    logic ok;
    ok = 1'b1;
    repeat (n)
    begin
      @(negedge clk);
      if (pick(w) !== v)
        ok = 1'b0;
    end
    chk({3'h0, ok}, 4'h1);
  endtask : hold

  // fault gone and breaker closed, so every undercurrent operates
  task idle;
    fault = 1'b0;
    rel = 1'b0;
    cb_cmd = 1'b0;
    cb_resp = 1'b0;
    subs = 1'b0;
    uc_set = 5'h00;
    for (int i = 0; i < 3; i++)
      wt(40, i, 0);
    repeat (3) @(negedge clk);
  endtask : idle

  // ****
  // scenarios
  // ****
  initial
  begin
    repeat (12) @(negedge clk);
    chk({1'b0, retrip, backtrip, zcd_active}, 4'h0);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    // simple mode, breaker stuck
    reset_starts_en = 1'b1;
    chk(starts_out, 4'hA);
    fault = 1'b1;
    hold(D1, 1, 0);
    wt(8, 1, 1);
    hold(D2, 0, 0);
    chk(starts_out, 4'h0);
    uc_set = 5'h1C;
    hold(10, 1, 1);
    uc_set = 5'h1E;
    wt(8, 1, 0);
    idle();
    // sensitive earth start, start outputs left alone this time
    src = 2'h1;
    reset_starts_en = 1'b0;
    fault = 1'b1;
    wt(D1 + 8, 1, 1);
    chk(starts_out, 4'hA);
    uc_set = 5'h1E;
    hold(10, 1, 1);
    uc_set = 5'h01;
    wt(8, 1, 0);
    idle();
    // retrip then delayed backtrip
    src = 2'h0;
    retrip_mode = 1'b1;
    fault = 1'b1;
    hold(D1, 0, 0);
    wt(8, 0, 1);
    hold(D2 - D1 - 6, 1, 0);
    wt(16, 1, 1);
    idle();
    // retrip opens the breaker
    cb_resp = 1'b1;
    fault = 1'b1;
    wt(D1 + 8, 0, 1);
    hold(D2, 1, 0);
    idle();
    // subsidence current after opening blocks outputs
    subs = 1'b1;
    fault = 1'b1;
    hold(HC + 10, 2, 0);
    wt(D1, 0, 1);
    cb_cmd = 1'b1;
    wt(HC + 6, 2, 1);
    wt(3, 0, 0);
    hold(12, 1, 0);
    subs = 1'b0;
    wt(8, 2, 0);
    idle();
    // external trip ignored while internal selected
    retrip_mode = 1'b0;
    src = 2'h3;
    fault = 1'b1;
    hold(D1 + 10, 1, 0);
    // internal trip ignored while external selected
    use_external = 1'b1;
    src = 2'h0;
    hold(D1 + 10, 1, 0);
    fault = 1'b0;
    // reset options for non-current and external starts
    for (int s = 2; s < 4; s++)
    begin
      for (int o = 0; o < 3; o++)
      begin
        use_external = (s == 3);
        src = 2'(s);
        ex_opt = bfp_pkg::bfp_rst_opt_e'((s == 3) ? o : (o + 1) % 3);
        nc_opt = bfp_pkg::bfp_rst_opt_e'((s == 3) ? (o + 1) % 3 : o);
        repeat (2) @(negedge clk);
        fault = 1'b1;
        wt(D1 + 8, 1, 1);
        rel = 1'b1;
        hold(10, 1, 1);
        rel = 1'b0;
        uc_set = 5'h1F;
        if (o == 0)
          wt(8, 1, 0);
        else
          hold(10, 1, 1);
        rel = 1'b1;
        if (o == 1)
          wt(8, 1, 0);
        else
          hold(10, 1, 0 == o ? 1'b0 : 1'b1);
        cb_cmd = 1'b1;
        wt(8, 1, 0);
        idle();
      end
    end
    results();
  end
endmodule : breaker_failure_protection_tb_top
